// ==== common/dsh_pkg.sv ====
// dsh_pkg: constants shared by the dual spi/i2c slave host port.
// assumes a register bank of up to 30 byte registers outside this block.
package dsh_pkg;
	// ==========================================================
	// spi command byte layout
	localparam int CMD_DIR_BIT = 7;
	localparam int SUBADDR_HI = 6;
	localparam int SUBADDR_LO = 5;
	localparam logic [1:0] SUBADDR_OK = 2'h1;
	localparam int PTR_HI = 4;
	localparam int PTR_W = 5;
	// ==========================================================
	// register space and i2c addressing
	localparam logic [4:0] PTR_LAST = 5'h1D;
	localparam logic [4:0] PTR_RESET = 5'h00;
	localparam logic [6:0] I2C_SLAVE_ADDR = 7'h51;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [2:0] BITCNT_LAST = 3'h7;
	typedef enum logic [2:0] {DSH_IDLE, DSH_ADDR, DSH_ACK, DSH_RX, DSH_TX, DSH_TXACK, DSH_IGNORE} dsh_state_t;
endpackage : dsh_pkg

// ==== hdl/dsh_host_port.sv ====
// dsh_host_port: shared-pin spi / i2c slave giving a host access to a register bank.
// assumes bus pins are asynchronous and sampled by clk far faster than the bus clock;
// the register bank answers rd_data combinationally-registered within one clk of rd_addr.
`timescale 1ns/1ps
`default_nettype none
module dsh_host_port (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic bus_select_pin,
	input wire logic scl_pin,
	input wire logic sda_ce_in,
	input wire logic serial_in_line,
	output logic sda_out,
	output logic sda_oe,
	output logic serial_out_line,
	output logic [4:0] rd_addr,
	input wire logic [7:0] rd_data,
	output logic wr_en,
	output logic [4:0] wr_addr,
	output logic [7:0] wr_data,
	output logic i2c_mode
);
	// ==========================================================
	// pin synchronisers
	logic [2:0] s_raw;
	logic [2:0] s_rise;
	logic [2:0] s_fall;
	logic sel_s;
	dsh_sync #(.W(3)) u_sync (
		.clk(clk),
		.rst_b(rst_b),
		.async_in({scl_pin, sda_ce_in, serial_in_line}),
		.sync_out(s_raw),
		.rise(s_rise),
		.fall(s_fall)
	);
	dsh_sync #(.W(1)) u_sel (
		.clk(clk),
		.rst_b(rst_b),
		.async_in(bus_select_pin),
		.sync_out(sel_s),
		.rise(),
		.fall()
	);
	logic scl;
	logic sda;
	logic din;
	logic scl_rise;
	logic scl_fall;
	assign scl = s_raw[2];
	assign sda = s_raw[1];
	assign din = s_raw[0];
	assign scl_rise = s_rise[2];
	assign scl_fall = s_fall[2];
	// ==========================================================
	// bus conditions
	logic i2c_r;
	logic start_c;
	logic stop_c;
	logic ce_idle;
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			i2c_r <= 1'b0;
		end else begin
			i2c_r <= sel_s;
		end
	end
	assign i2c_mode = i2c_r;
	// edge seen while scl held high is a control condition
	assign start_c = i2c_r && scl && !scl_rise && s_fall[1];
	assign stop_c = i2c_r && scl && !scl_rise && s_rise[1];
	assign ce_idle = !i2c_r && sda;
	// ==========================================================
	// shared shifter and state
	dsh_pkg::dsh_state_t state_r;
	logic [7:0] sh_r;
	logic [2:0] bit_r;
	logic is_read_r;
	logic first_r;
	logic [7:0] tx_r;
	logic byte_done;
	logic [7:0] rx_byte;
	logic ptr_clr;
	logic ptr_load;
	logic [4:0] ptr_val;
	logic ptr_step;
	logic [4:0] ptr;
	// ==========================================================
	// shared decode
	// the subaddress test gates both the pointer load and the frame state
	function automatic logic cmd_ok(input logic [7:0] b);
		return b[dsh_pkg::SUBADDR_HI:dsh_pkg::SUBADDR_LO] == dsh_pkg::SUBADDR_OK;
	endfunction : cmd_ok
	// first bit of a byte comes straight from the bank, the rest from the held copy
	function automatic logic next_tx(input logic [2:0] n, input logic [7:0] fresh, input logic [7:0] held);
		return (n == 3'h0) ? fresh[7] : held[~n];
	endfunction : next_tx
	assign rx_byte = {sh_r[6:0], i2c_r ? sda : din};
	assign byte_done = scl_rise && bit_r == dsh_pkg::BITCNT_LAST;
	dsh_ptr u_ptr (
		.clk(clk),
		.rst_b(rst_b),
		.clr(ptr_clr),
		.load(ptr_load),
		.load_val(ptr_val),
		.step(ptr_step),
		.ptr(ptr)
	);
	assign ptr_clr = 1'b0;
	always_comb begin
		ptr_load = 1'b0;
		ptr_val = rx_byte[dsh_pkg::PTR_HI:0];
		ptr_step = 1'b0;
		if (!i2c_r) begin
			if (state_r == dsh_pkg::DSH_ADDR && byte_done) begin
				ptr_load = cmd_ok(rx_byte);
			end else if ((state_r == dsh_pkg::DSH_RX || state_r == dsh_pkg::DSH_TX) && byte_done) begin
				ptr_step = 1'b1;
			end
		end else begin
			if (state_r == dsh_pkg::DSH_RX && byte_done) begin
				ptr_load = first_r;
				ptr_step = !first_r;
			end else if (state_r == dsh_pkg::DSH_TX && byte_done) begin
				ptr_step = 1'b1;
			end
		end
	end
	assign rd_addr = ptr;
	// ==========================================================
	// bit counter and shift register
	always_ff @(posedge clk) begin
		if (!rst_b || ce_idle || start_c || stop_c) begin
			bit_r <= 3'h0;
			sh_r <= dsh_pkg::BYTE_RESET;
		end else if (scl_rise && state_r != dsh_pkg::DSH_ACK && state_r != dsh_pkg::DSH_TXACK) begin
			bit_r <= bit_r + 3'h1;
			sh_r <= rx_byte;
		end
	end
	// ==========================================================
	// protocol state
	always_ff @(posedge clk) begin
		if (!rst_b || ce_idle) begin
			state_r <= dsh_pkg::DSH_ADDR;
			is_read_r <= 1'b0;
			first_r <= 1'b0;
		end else if (start_c) begin
			state_r <= dsh_pkg::DSH_ADDR;
		end else if (stop_c) begin
			state_r <= dsh_pkg::DSH_IDLE;
		end else if (!i2c_r) begin
			if (state_r == dsh_pkg::DSH_ADDR && byte_done) begin
				is_read_r <= rx_byte[dsh_pkg::CMD_DIR_BIT];
				if (!cmd_ok(rx_byte)) begin
					state_r <= dsh_pkg::DSH_IGNORE;
				end else begin
					state_r <= rx_byte[dsh_pkg::CMD_DIR_BIT] ? dsh_pkg::DSH_TX : dsh_pkg::DSH_RX;
				end
			end else if (state_r == dsh_pkg::DSH_IDLE) begin
				state_r <= dsh_pkg::DSH_ADDR;
			end
		end else begin
			case (state_r)
				dsh_pkg::DSH_ADDR: begin
					if (byte_done) begin
						if (rx_byte[7:1] == dsh_pkg::I2C_SLAVE_ADDR) begin
							is_read_r <= rx_byte[0];
							first_r <= !rx_byte[0];
							state_r <= dsh_pkg::DSH_ACK;
						end else begin
							state_r <= dsh_pkg::DSH_IGNORE;
						end
					end
				end
				dsh_pkg::DSH_RX: begin
					if (byte_done) begin
						state_r <= dsh_pkg::DSH_ACK;
					end
				end
				dsh_pkg::DSH_ACK: begin
					if (scl_rise) begin
						state_r <= is_read_r ? dsh_pkg::DSH_TX : dsh_pkg::DSH_RX;
					end
				end
				dsh_pkg::DSH_TX: begin
					if (byte_done) begin
						state_r <= dsh_pkg::DSH_TXACK;
					end
				end
				dsh_pkg::DSH_TXACK: begin
					if (scl_rise) begin
						// nack: the host will stop, stay off the line
						state_r <= sda ? dsh_pkg::DSH_IGNORE : dsh_pkg::DSH_TX;
					end
				end
				default: begin
					state_r <= state_r;
				end
			endcase
			if (state_r == dsh_pkg::DSH_RX && byte_done) begin
				first_r <= 1'b0;
			end
		end
	end
	// ==========================================================
	// register bank writes
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			wr_en <= 1'b0;
			wr_addr <= dsh_pkg::PTR_RESET;
			wr_data <= dsh_pkg::BYTE_RESET;
		end else begin
			wr_en <= state_r == dsh_pkg::DSH_RX && byte_done && !(i2c_r && first_r) && !ce_idle;
			wr_addr <= ptr;
			wr_data <= rx_byte;
		end
	end
	// ==========================================================
	// transmit data and pin drive
	// reload only while the bus clock is low, so the copy is settled before the next fall
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			tx_r <= dsh_pkg::BYTE_RESET;
		end else if (bit_r == 3'h0 && !scl) begin
			tx_r <= rd_data;
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			serial_out_line <= 1'b0;
		end else if (!i2c_r && scl_fall && state_r == dsh_pkg::DSH_TX) begin
			serial_out_line <= next_tx(bit_r, rd_data, tx_r);
		end
	end
	// open-drain data line: only ever drives low, as a slave
	always_ff @(posedge clk) begin
		if (!rst_b || !i2c_r || start_c || stop_c) begin
			sda_oe <= 1'b0;
		end else if (scl_fall) begin
			if (state_r == dsh_pkg::DSH_ACK) begin
				sda_oe <= 1'b1;
			end else if (state_r == dsh_pkg::DSH_TX) begin
				sda_oe <= !next_tx(bit_r, rd_data, tx_r);
			end else begin
				sda_oe <= 1'b0;
			end
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			sda_out <= 1'b0;
		end else begin
			sda_out <= 1'b0;
		end
	end
endmodule : dsh_host_port
`default_nettype wire

// ==== hdl/dsh_ptr.sv ====
// dsh_ptr: register address counter with wrap after the last valid register.
// assumes load and step are single-cycle pulses on clk.
`timescale 1ns/1ps
`default_nettype none
module dsh_ptr (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic clr,
	input wire logic load,
	input wire logic [4:0] load_val,
	input wire logic step,
	output logic [4:0] ptr
);
	always_ff @(posedge clk) begin
		if (!rst_b || clr) begin
			ptr <= dsh_pkg::PTR_RESET;
		end else if (load) begin
			ptr <= load_val;
		end else if (step) begin
			ptr <= (ptr >= dsh_pkg::PTR_LAST) ? dsh_pkg::PTR_RESET : ptr + 5'h01;
		end
	end
endmodule : dsh_ptr
`default_nettype wire

// ==== hdl/dsh_sync.sv ====
// dsh_sync: two-flop synchroniser with edge flags on the second stage output.
// assumes inputs asynchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module dsh_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out,
	output logic [W-1:0] rise,
	output logic [W-1:0] fall
);
	logic [W-1:0] meta_r;
	logic [W-1:0] prev_r;
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			meta_r <= '1;
			sync_out <= '1;
			prev_r <= '1;
		end else begin
			meta_r <= async_in;
			sync_out <= meta_r;
			prev_r <= sync_out;
		end
	end
	assign rise = sync_out & ~prev_r;
	assign fall = ~sync_out & prev_r;
endmodule : dsh_sync
`default_nettype wire

// ==== verification/dsh_host.sv ====
// dsh_host: behavioural spi / i2c bus controller on the shared pins.
// assumes sda is pulled up; one bit takes 64 ns.
`timescale 1ns/1ps
`default_nettype none
module dsh_host (
	input wire logic sda_oe,
	input wire logic so,
	output logic scl,
	output wire logic sda_ce,
	output logic si
);
	logic line_h = 1'b1;
	initial begin
		scl = 1'b0;
		si = 1'b0;
	end
	// ====
	// bus wire and tasks
	assign sda_ce = line_h & ~sda_oe;
	task automatic bit_io(input logic b, output logic r, input logic spi);
		if (spi) si = b;
		else line_h = b;
		#36 scl = 1'b1;
		#20 r = spi ? so : sda_ce;
		#4 scl = 1'b0;
		// stale data must not look valid
		#4 si = ~si;
	endtask : bit_io
	task automatic xfer(input logic [7:0] b, output logic [7:0] q, input logic spi);
		for (int i = 7; i >= 0; i--) bit_io(b[i], q[i], spi);
	endtask : xfer
	task automatic ce_set(input logic v);
		line_h = v;
		#32;
	endtask : ce_set
	task automatic start;
		line_h = 1'b1;
		#32 scl = 1'b1;
		#32 line_h = 1'b0;
		#32 scl = 1'b0;
		#4;
	endtask : start
	task automatic stop;
		line_h = 1'b0;
		#32 scl = 1'b1;
		#32 line_h = 1'b1;
		#32;
	endtask : stop
endmodule : dsh_host
`default_nettype wire

// ==== verification/dsh_properties.sv ====
// dsh_props: port-level properties of dsh_host_port.
// assumes bus pins stay put for at least 3 clk.
`timescale 1ns/1ps
`default_nettype none
module dsh_props (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic bus_select_pin,
	input wire logic scl_pin,
	input wire logic sda_ce_in,
	input wire logic serial_in_line,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic serial_out_line,
	input wire logic [4:0] rd_addr,
	input wire logic [7:0] rd_data,
	input wire logic wr_en,
	input wire logic [4:0] wr_addr,
	input wire logic [7:0] wr_data,
	input wire logic i2c_mode
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// ====
	// properties
	a_mode_follows_pin: assert property ($stable(bus_select_pin) [*6] |-> i2c_mode == bus_select_pin)
		else $error("mode");
	a_spi_no_drive: assert property (!i2c_mode |-> !sda_oe)
		else $error("sda in spi");
	a_ce_high_quiet: assert property ((!i2c_mode && sda_ce_in) [*4] |-> !wr_en)
		else $error("write outside frame");
	a_write_after_rise: assert property (wr_en |-> $past(scl_pin, 2))
		else $error("write timing");
	a_out_on_fall: assert property (!i2c_mode && !sda_ce_in && $changed(serial_out_line) |-> !$past(scl_pin, 2))
		else $error("out timing");
	a_wr_one_cycle: assert property (wr_en |=> !wr_en)
		else $error("wr pulse");
	a_wr_addr_range: assert property (wr_en |-> wr_addr <= dsh_pkg::PTR_LAST)
		else $error("wr addr");
	a_ack_held: assert property ($rose(sda_oe) |-> sda_oe [*6])
		else $error("ack short");
	a_open_drain: assert property (!sda_out)
		else $error("sda high");
endmodule : dsh_props
bind dsh_host_port dsh_props dsh_props_inst (.clk(clk), .rst_b(rst_b), .bus_select_pin(bus_select_pin),
	.scl_pin(scl_pin), .sda_ce_in(sda_ce_in), .serial_in_line(serial_in_line), .sda_out(sda_out),
	.sda_oe(sda_oe), .serial_out_line(serial_out_line), .rd_addr(rd_addr), .rd_data(rd_data),
	.wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .i2c_mode(i2c_mode));
`default_nettype wire

// ==== verification/tb.sv ====
// tb: random and corner spi / i2c traffic through dsh_host_port.
// assumes the bank answers one clk after rd_addr.
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic bus_select_pin = 1'b0;
	logic scl_pin, sda_ce_in, serial_in_line, sda_out, sda_oe, serial_out_line, wr_en, i2c_mode, k;
	logic [4:0] rd_addr, wr_addr, a;
	logic [7:0] rd_data = 8'h00;
	logic [7:0] wr_data, d, q;
	logic [12:0] wq[$];
	logic [12:0] eq[$];
	int bad_count = 0;
	int n_checks = 0;
	initial forever #4 clk = ~clk;
	dsh_host_port dsh_host_port_inst (.clk(clk), .rst_b(rst_b), .bus_select_pin(bus_select_pin),
		.scl_pin(scl_pin), .sda_ce_in(sda_ce_in), .serial_in_line(serial_in_line), .sda_out(sda_out),
		.sda_oe(sda_oe), .serial_out_line(serial_out_line), .rd_addr(rd_addr), .rd_data(rd_data),
		.wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .i2c_mode(i2c_mode));
	dsh_host dsh_host_inst (.sda_oe(sda_oe), .so(serial_out_line), .scl(scl_pin), .sda_ce(sda_ce_in),
		.si(serial_in_line));
	function automatic logic [7:0] bank(input logic [4:0] x);
		return {x[2:0], x} ^ 8'hA5;
	endfunction : bank
	function automatic logic [4:0] nxt(input logic [4:0] x);
		return (x == 5'h1D) ? 5'h00 : x + 5'h01;
	endfunction : nxt
	always @(posedge clk) rd_data <= bank(rd_addr);
	always @(posedge clk) if (wr_en === 1'b1) wq.push_back({wr_addr, wr_data});
	// ====
	// checking and sequencing
	task automatic check(input string w, input logic [12:0] s, input logic [12:0] e);
		n_checks++;
		if (s !== e) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", w, e, s);
		end
	endtask : check
	task automatic report_and_stop;
		$display("checks %0d errors %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : report_and_stop
	task automatic do_reset(input logic sel);
		@(posedge clk) #1 rst_b = 1'b0;
		bus_select_pin = sel;
		repeat (5) @(posedge clk);
		#1 rst_b = 1'b1;
		repeat (8) @(posedge clk);
		check("mode", {12'h000, i2c_mode}, {12'h000, sel});
		// keep every later pin change off the sampling edge
		#1;
	endtask : do_reset
	task automatic drain;
		repeat (10) @(posedge clk);
		check("wcount", 13'(wq.size()), 13'(eq.size()));
		while (eq.size() > 0 && wq.size() > 0) check("wr", wq.pop_front(), eq.pop_front());
		wq.delete();
		eq.delete();
		#1;
	endtask : drain
	task automatic spi(input logic [7:0] cmd, input int n);
		logic [4:0] p;
		logic [7:0] v, r;
		p = cmd[4:0];
		dsh_host_inst.ce_set(1'b0);
		dsh_host_inst.xfer(cmd, r, 1'b1);
		repeat (n) begin
			v = 8'($urandom);
			dsh_host_inst.xfer(v, r, 1'b1);
			if (cmd[6:5] == dsh_pkg::SUBADDR_OK && cmd[7]) check("rd", {5'h00, r}, {5'h00, bank(p)});
			if (cmd[6:5] == dsh_pkg::SUBADDR_OK && !cmd[7]) eq.push_back({p, v});
			p = nxt(p);
		end
		dsh_host_inst.ce_set(1'b1);
		drain();
	endtask : spi
	task automatic i2c(input logic [7:0] b, input logic ack, output logic [7:0] r);
		logic x;
		dsh_host_inst.xfer(b, r, 1'b0);
		dsh_host_inst.bit_io(1'b1, x, 1'b0);
		check("ack", {12'h000, x}, {12'h000, ack});
	endtask : i2c
	initial begin
		void'($urandom(5));
		do_reset(1'b0);
		spi({3'b001, 5'h1C}, 3);
		for (int s = 0; s < 4; s++) spi({1'b0, 2'(s), 5'($urandom % 30)}, 2);
		dsh_host_inst.ce_set(1'b0);
		repeat (3) dsh_host_inst.bit_io(1'b1, k, 1'b1);
		dsh_host_inst.ce_set(1'b1);
		repeat (4) spi({3'b101, 5'($urandom % 30)}, 3);
		do_reset(1'b1);
		a = 5'($urandom % 30);
		d = 8'($urandom);
		dsh_host_inst.start();
		i2c(8'hA4, 1'b1, q);
		dsh_host_inst.stop();
		dsh_host_inst.start();
		i2c({dsh_pkg::I2C_SLAVE_ADDR, 1'b0}, 1'b0, q);
		i2c({3'h0, a}, 1'b0, q);
		i2c(d, 1'b0, q);
		dsh_host_inst.stop();
		eq.push_back({a, d});
		drain();
		dsh_host_inst.start();
		i2c({dsh_pkg::I2C_SLAVE_ADDR, 1'b1}, 1'b0, q);
		i2c(8'hFF, 1'b1, q);
		dsh_host_inst.stop();
		check("i2c rd", {5'h00, q}, {5'h00, bank(nxt(a))});
		report_and_stop();
	end
	initial begin
		#200000;
		bad_count++;
		report_and_stop();
	end
endmodule : tb
`default_nettype wire
